/* rtl/mcu_irq_pkg.sv */
// constants for the interrupt request and wake-up block
// assumes a 32-bit classic wishbone slave port and one system clock
package mcu_irq_pkg;

   // -------------------------------------------------------------------
   // register map, byte addresses
   // -------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam logic [ADDR_W-1:0] OFS_TB0_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TB1_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CLK_SRC = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_REQ_EN = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_REQ_FLAG = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_SRC_EN = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SRC_FLAG = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STACK = 8'h20;

   // -------------------------------------------------------------------
   // time base control fields
   // -------------------------------------------------------------------
   localparam int TB_RUN_BIT = 7;
   localparam int TB_SEL_W = 3;
   localparam int TB_MIN_EXP = 8;
   localparam int TB_CNT_W = 15;
   localparam int CLK_SRC_W = 2;
   localparam int CLK_SRC1_LSB = 2;
   localparam logic [CLK_SRC_W-1:0] CLK_FROM_SYS = 2'h0;
   localparam logic [CLK_SRC_W-1:0] CLK_FROM_SYS_DIV4 = 2'h1;
   localparam int CLK_SUB_BIT = 1;
   localparam int DIV4_W = 2;
   localparam logic [DIV4_W-1:0] DIV4_LAST = 2'h3;
   localparam logic [REG_W-1:0] TB_CTRL_RESET = 8'h00;
   localparam logic [CLK_SRC_W-1:0] CLK_SRC_RESET = 2'h0;

   // -------------------------------------------------------------------
   // requests, in vector order: lowest index is served first
   // -------------------------------------------------------------------
   localparam int NUM_REQ = 8;
   localparam int REQ_IDX_W = 3;
   localparam int REQ_SIF = 0;
   localparam int REQ_UART0 = 1;
   localparam int REQ_UART1 = 2;
   localparam int REQ_TB0 = 3;
   localparam int REQ_TB1 = 4;
   localparam int REQ_GRP0 = 5;
   localparam int REQ_GRP1 = 6;
   localparam int REQ_GRP2 = 7;
   localparam int GLOBAL_EN_BIT = 0;

   // -------------------------------------------------------------------
   // grouped sources and their group membership
   // -------------------------------------------------------------------
   localparam int NUM_SRC = 6;
   localparam int SRC_TM0_A = 0;
   localparam int SRC_TM0_P = 1;
   localparam int SRC_TM1_A = 2;
   localparam int SRC_TM1_P = 3;
   localparam int SRC_LOW_SUPPLY = 4;
   localparam int SRC_NVM_DONE = 5;
   localparam logic [NUM_SRC-1:0] GRP0_MEMBERS = 6'h03;
   localparam logic [NUM_SRC-1:0] GRP1_MEMBERS = 6'h0C;
   localparam logic [NUM_SRC-1:0] GRP2_MEMBERS = 6'h30;
   localparam int NUM_TM = 2;
   localparam int SIF_EV_W = 3;
   localparam int UART_EV_W = 6;

   // -------------------------------------------------------------------
   // hardware stack
   // -------------------------------------------------------------------
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam int STACK_IDX_W = 3;
   localparam int STACK_LVL_W = 4;
   localparam logic [STACK_LVL_W-1:0] STACK_FULL_LVL = 4'h8;
   localparam int STACK_FULL_BIT = 4;

endpackage

/* rtl/tick_gen.sv */
// one time base: prescaler clock selection and period counter
// assumes sub_tick_i is a one-cycle enable at the low-speed rate
`timescale 1ns/1ps
module tick_gen
   import mcu_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [TB_SEL_W-1:0] period_sel_i,
   input wire logic [CLK_SRC_W-1:0] clk_source_i,
   input wire logic sub_tick_i,
   // time-out
   output logic timeout_o
);

   logic [DIV4_W-1:0] div4;
   logic [TB_CNT_W-1:0] cnt;
   logic [TB_CNT_W-1:0] mask;
   logic psc_tick;

   // -------------------------------------------------------------------
   // prescaler clock
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div4 <= '0;
      end else begin
         div4 <= div4 + 1'b1;
      end
   end

   always_comb begin
      if (clk_source_i[CLK_SUB_BIT]) begin
         psc_tick = sub_tick_i;
      end else if (clk_source_i == CLK_FROM_SYS_DIV4) begin
         psc_tick = (div4 == DIV4_LAST);
      end else begin
         psc_tick = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // period counter
   // -------------------------------------------------------------------
   // mask of the low bits that must all be ones at the end of a period
   always_comb begin
      mask = TB_CNT_W'((1 << (int'(period_sel_i) + TB_MIN_EXP)) - 1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt <= '0;
      end else if (psc_tick) begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timeout_o <= 1'b0;
      end else begin
         timeout_o <= run_i && psc_tick && ((cnt & mask) == mask);
      end
   end

endmodule

/* rtl/mcu_irq_ctrl.sv */
// interrupt request, enable, service and wake-up logic with time bases
// assumes the core pulses ack/call/ret one cycle each, never together
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module mcu_irq_ctrl
   import mcu_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [DATA_W-1:0] dat_i,
   output logic [DATA_W-1:0] dat_o,
   output logic ack_o,
   // request sources
   input wire logic sub_tick_i,
   input wire logic [NUM_TM-1:0] tm_match_a_i,
   input wire logic [NUM_TM-1:0] tm_match_p_i,
   input wire logic low_supply_i,
   input wire logic nvm_done_i,
   input wire logic [SIF_EV_W-1:0] serial_if_event_i,
   input wire logic [UART_EV_W-1:0] uart0_event_i,
   input wire logic [UART_EV_W-1:0] uart1_event_i,
   // processor core
   input wire logic irq_ack_i,
   input wire logic call_i,
   input wire logic ret_i,
   input wire logic return_from_isr_i,
   input wire logic [PC_W-1:0] pc_i,
   output logic irq_req_o,
   output logic [REQ_IDX_W-1:0] irq_vector_o,
   output logic [PC_W-1:0] return_pc_o,
   output logic stack_full_o,
   output logic wake_o
);

   logic tick0_run;
   logic tick1_run;
   logic [TB_SEL_W-1:0] tick0_period_sel;
   logic [TB_SEL_W-1:0] tick1_period_sel;
   logic [CLK_SRC_W-1:0] tick0_clk_source;
   logic [CLK_SRC_W-1:0] tick1_clk_source;
   logic tick0_timeout;
   logic tick1_timeout;
   logic global_irq_enable;
   logic [NUM_REQ-1:0] req_en;
   logic [NUM_REQ-1:0] req_flag;
   logic [NUM_REQ-1:0] req_flag_d;
   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0] src_flag;
   logic [NUM_SRC-1:0] src_flag_d;
   logic [NUM_REQ-1:0] req_set;
   logic [NUM_REQ-1:0] req_clr;
   logic [NUM_SRC-1:0] src_set;
   logic [NUM_SRC-1:0] src_hit;
   logic [NUM_REQ-1:0] pending;
   logic [REQ_IDX_W-1:0] next_vector;
   logic take;
   logic bus_req;
   logic wr;
   logic [REG_W-1:0] wdata;
   logic [REG_W-1:0] rdata;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [STACK_LVL_W-1:0] stack_lvl;
   logic stack_full;
   logic pop;

   // -------------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------------
   assign bus_req = cyc_i && stb_i && !ack_o;
   // only byte lane 0 carries register data
   assign wr = bus_req && we_i && sel_i[0];
   assign wdata = dat_i[REG_W-1:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req;
      end
   end

   // -------------------------------------------------------------------
   // time base control and prescaler source
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {tick0_run, tick0_period_sel} <= '0;
         {tick1_run, tick1_period_sel} <= '0;
      end else if (wr && adr_i == OFS_TB0_CTRL) begin
         tick0_run <= wdata[TB_RUN_BIT];
         tick0_period_sel <= wdata[TB_SEL_W-1:0];
      end else if (wr && adr_i == OFS_TB1_CTRL) begin
         tick1_run <= wdata[TB_RUN_BIT];
         tick1_period_sel <= wdata[TB_SEL_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick0_clk_source <= CLK_SRC_RESET;
         tick1_clk_source <= CLK_SRC_RESET;
      end else if (wr && adr_i == OFS_CLK_SRC) begin
         tick0_clk_source <= wdata[CLK_SRC_W-1:0];
         tick1_clk_source <= wdata[CLK_SRC1_LSB +: CLK_SRC_W];
      end
   end

   tick_gen u_tick0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(tick0_run),
      .period_sel_i(tick0_period_sel),
      .clk_source_i(tick0_clk_source),
      .sub_tick_i(sub_tick_i),
      .timeout_o(tick0_timeout)
   );

   tick_gen u_tick1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(tick1_run),
      .period_sel_i(tick1_period_sel),
      .clk_source_i(tick1_clk_source),
      .sub_tick_i(sub_tick_i),
      .timeout_o(tick1_timeout)
   );

   // -------------------------------------------------------------------
   // enables
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_en <= '0;
         src_en <= '0;
      end else if (wr && adr_i == OFS_REQ_EN) begin
         req_en <= wdata;
      end else if (wr && adr_i == OFS_SRC_EN) begin
         src_en <= wdata[NUM_SRC-1:0];
      end
   end

   // -------------------------------------------------------------------
   // grouped source flags
   // -------------------------------------------------------------------
   always_comb begin
      src_set = '0;
      src_set[SRC_TM0_A] = tm_match_a_i[0];
      src_set[SRC_TM0_P] = tm_match_p_i[0];
      src_set[SRC_TM1_A] = tm_match_a_i[1];
      src_set[SRC_TM1_P] = tm_match_p_i[1];
      src_set[SRC_LOW_SUPPLY] = low_supply_i;
      src_set[SRC_NVM_DONE] = nvm_done_i;
   end

   // a source reaches its group only through its own enable
   assign src_hit = src_set & src_en;

   // service never touches these; only software writes clear them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_flag <= '0;
      end else if (wr && adr_i == OFS_SRC_FLAG) begin
         src_flag <= wdata[NUM_SRC-1:0] | src_set;
      end else begin
         src_flag <= src_flag | src_set;
      end
   end

   // -------------------------------------------------------------------
   // request flags
   // -------------------------------------------------------------------
   always_comb begin
      req_set = '0;
      req_set[REQ_SIF] = |serial_if_event_i;
      req_set[REQ_UART0] = |uart0_event_i;
      req_set[REQ_UART1] = |uart1_event_i;
      req_set[REQ_TB0] = tick0_timeout;
      req_set[REQ_TB1] = tick1_timeout;
      req_set[REQ_GRP0] = |(src_hit & GRP0_MEMBERS);
      req_set[REQ_GRP1] = |(src_hit & GRP1_MEMBERS);
      req_set[REQ_GRP2] = |(src_hit & GRP2_MEMBERS);
   end

   // servicing clears only the flag of the vector taken
   always_comb begin
      req_clr = '0;
      if (take) begin
         req_clr[irq_vector_o] = 1'b1;
      end
   end

   // a new event beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_flag <= '0;
      end else if (wr && adr_i == OFS_REQ_FLAG) begin
         req_flag <= wdata | req_set;
      end else begin
         req_flag <= (req_flag & ~req_clr) | req_set;
      end
   end

   // -------------------------------------------------------------------
   // global enable
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         global_irq_enable <= 1'b0;
      end else if (take) begin
         global_irq_enable <= 1'b0;
      end else if (return_from_isr_i) begin
         global_irq_enable <= 1'b1;
      end else if (wr && adr_i == OFS_GLOBAL) begin
         global_irq_enable <= wdata[GLOBAL_EN_BIT];
      end
   end

   // -------------------------------------------------------------------
   // arbitration and vector request
   // -------------------------------------------------------------------
   assign pending = req_flag & req_en;
   assign take = irq_ack_i && irq_req_o;

   always_comb begin
      next_vector = '0;
      for (int i = NUM_REQ - 1; i >= 0; i--) begin
         if (pending[i]) begin
            next_vector = REQ_IDX_W'(i);
         end
      end
   end

   // the request drops at once on take so one ack cannot serve twice
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_req_o <= 1'b0;
         irq_vector_o <= '0;
      end else begin
         irq_req_o <= global_irq_enable && (|pending) && !stack_full
            && !take && !call_i;
         irq_vector_o <= next_vector;
      end
   end

   // -------------------------------------------------------------------
   // hardware stack
   // -------------------------------------------------------------------
   assign stack_full = (stack_lvl == STACK_FULL_LVL);
   assign pop = (ret_i || return_from_isr_i) && stack_lvl != '0;

   // only the program counter is saved; the core keeps the rest
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stack_lvl <= '0;
      end else if ((take || call_i) && !stack_full) begin
         stack_mem[stack_lvl[STACK_IDX_W-1:0]] <= pc_i;
         stack_lvl <= stack_lvl + 1'b1;
      end else if (pop) begin
         stack_lvl <= stack_lvl - 1'b1;
      end
   end

   // a call with a full stack is dropped, the return then goes astray
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         return_pc_o <= '0;
         stack_full_o <= 1'b0;
      end else begin
         if (pop) begin
            return_pc_o <= stack_mem[STACK_IDX_W'(stack_lvl - 1'b1)];
         end
         stack_full_o <= stack_full;
      end
   end

   // -------------------------------------------------------------------
   // wake-up on any rising flag; only src_en plays a part, by gating the group request flags
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_flag_d <= '0;
         src_flag_d <= '0;
         wake_o <= 1'b0;
      end else begin
         req_flag_d <= req_flag;
         src_flag_d <= src_flag;
         wake_o <= |(req_flag & ~req_flag_d)
            || |(src_flag & ~src_flag_d);
      end
   end

   // -------------------------------------------------------------------
   // read back
   // -------------------------------------------------------------------
   always_comb begin
      case (adr_i)
         OFS_TB0_CTRL: rdata = {tick0_run, 4'h0, tick0_period_sel};
         OFS_TB1_CTRL: rdata = {tick1_run, 4'h0, tick1_period_sel};
         OFS_CLK_SRC: rdata = {4'h0, tick1_clk_source, tick0_clk_source};
         OFS_GLOBAL: rdata = {7'h00, global_irq_enable};
         OFS_REQ_EN: rdata = req_en;
         OFS_REQ_FLAG: rdata = req_flag;
         OFS_SRC_EN: rdata = {2'h0, src_en};
         OFS_SRC_FLAG: rdata = {2'h0, src_flag};
         OFS_STACK: rdata = {3'h0, stack_full, stack_lvl};
         default: rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (bus_req && !we_i) begin
         dat_o <= {24'h000000, rdata};
      end else begin
         dat_o <= '0;
      end
   end

endmodule

/* dv/mcu_irq_properties.sv */
// port checks for the interrupt request block
// assumes it is bound to mcu_irq_ctrl and sees only its ports
`timescale 1ns/1ps
module mcu_irq_properties
   import mcu_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [DATA_W-1:0] dat_o,
   input wire logic ack_o,
   // core
   input wire logic irq_ack_i,
   input wire logic call_i,
   input wire logic ret_i,
   input wire logic return_from_isr_i,
   input wire logic [PC_W-1:0] pc_i,
   input wire logic irq_req_o,
   input wire logic [PC_W-1:0] return_pc_o,
   input wire logic stack_full_o,
   input wire logic wake_o
);
   // ---------------------------------------------------------------
   // shadow of the newest stack entry
   // ---------------------------------------------------------------
   logic [PC_W-1:0] top_pc;
   logic top_ok;
   logic push;
   logic pop;
   assign push = (irq_ack_i && irq_req_o || call_i) && !stack_full_o;
   assign pop = ret_i || return_from_isr_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         top_ok <= 1'b0;
         top_pc <= '0;
      end else if (push) begin
         top_ok <= 1'b1;
         top_pc <= pc_i;
      end else if (pop) begin
         top_ok <= 1'b0;
      end
   end
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (
      cyc_i && stb_i && !ack_o |=> ack_o) else $error("no bus ack");
   a_ack_pulse: assert property (
      ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property (
      ack_o |-> $past(cyc_i) && $past(stb_i)) else $error("stray ack");
   a_read_idle: assert property (
      !ack_o |-> dat_o == '0) else $error("read data outside ack");
   a_take_drops: assert property (
      irq_ack_i && irq_req_o |=> !irq_req_o) else $error("req after take");
   a_global_cleared: assert property (
      irq_ack_i && irq_req_o ##1 !return_from_isr_i && !cyc_i
      |=> !irq_req_o) else $error("global enable kept after take");
   a_full_blocks: assert property (
      stack_full_o [*3] |-> !irq_req_o) else $error("req with stack full");
   a_full_cause: assert property (
      $rose(stack_full_o) |-> $past(push) || $past(push, 2))
      else $error("stack full without push");
   a_pop_pc: assert property (
      pop && top_ok |=> return_pc_o == top_pc) else $error("wrong popped pc");
   c_take: cover property (irq_ack_i && irq_req_o);
   c_full: cover property (stack_full_o);
   c_wake: cover property (wake_o);
   c_pop: cover property (pop && top_ok);
endmodule

/* dv/core_model.sv */
// model of the core that takes requests and returns from them
// assumes bench codes last one cycle: 1 call, 2 ret, 3 return_from_isr
`timescale 1ns/1ps
module core_model
   import mcu_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bench control
   input wire logic [3:0] take_delay_i,
   input wire logic [1:0] cmd_i,
   // block side
   input wire logic irq_req_i,
   output logic irq_ack_o,
   output logic call_o,
   output logic ret_o,
   output logic return_from_isr_o,
   output logic [PC_W-1:0] pc_o
);
   logic [3:0] wait_cnt;
   // free-running pc, so every push carries a fresh value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_o <= 13'h0100;
      end else begin
         pc_o <= pc_o + 13'h0001;
      end
   end
   // a bench command holds off the take: one core action per cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || !irq_req_i || irq_ack_o) begin
         wait_cnt <= 4'h0;
         irq_ack_o <= 1'b0;
      end else if (wait_cnt >= take_delay_i && cmd_i == 2'h0) begin
         irq_ack_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      call_o <= !rst_i && cmd_i == 2'h1;
      ret_o <= !rst_i && cmd_i == 2'h2;
      return_from_isr_o <= !rst_i && cmd_i == 2'h3;
   end
endmodule

/* dv/mcu_irq_ctrl_tb.sv */
// self-checking bench for the interrupt request block
// assumes the core model and checker are compiled before it
`timescale 1ns/1ps
module mcu_irq_ctrl_tb
   import mcu_irq_pkg::*;
;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } row_s;
   row_s rows [13] = '{
      '{1'b0, OFS_TB0_CTRL, 8'h00, 8'h00}, '{1'b0, OFS_GLOBAL, 8'h0, 8'h0},
      '{1'b0, OFS_STACK, 8'h00, 8'h00}, '{1'b1, OFS_TB0_CTRL, 8'hFF, 8'h0},
      '{1'b0, OFS_TB0_CTRL, 8'h00, 8'h87}, '{1'b1, OFS_TB0_CTRL, 8'h0, 8'h0},
      '{1'b1, OFS_TB1_CTRL, 8'h7A, 8'h00}, '{1'b0, OFS_TB1_CTRL, 8'h0, 8'h2},
      '{1'b1, OFS_CLK_SRC, 8'h0F, 8'h00}, '{1'b0, OFS_CLK_SRC, 8'h0, 8'h0F},
      '{1'b0, 8'h40, 8'h00, 8'h00}, '{1'b1, OFS_REQ_EN, 8'hFF, 8'h00},
      '{1'b0, OFS_REQ_EN, 8'h00, 8'hFF}};
   int tb_sel [6] = '{1, 0, 0, 0, 2, 7};
   int tb_src [6] = '{0, 1, 2, 3, 0, 0};
   int tb_exp [6] = '{512, 1024, 768, 768, 1024, 32768};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, we = 1'b0, sub_tick = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, rsp;
   logic [14:0] ev = 15'h0;
   logic [5:0] src_ev = 6'h00;
   logic [1:0] cmd = 2'h0;
   logic [3:0] delay = 4'h0;
   logic ack, irq_ack, call, ret, return_from_isr, irq_req, stack_full, wake;
   logic [2:0] vec, taken_vec;
   logic [PC_W-1:0] pc, ret_pc, taken_pc;
   int n_errors = 0, n_tests = 0, takes = 0, wakes = 0, cycles = 0, w0, t0;
   always #2.5 clk_i = ~clk_i;
   mcu_irq_ctrl mcu_irq_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .sub_tick_i(sub_tick), .tm_match_a_i({src_ev[2], src_ev[0]}),
      .tm_match_p_i({src_ev[3], src_ev[1]}), .low_supply_i(src_ev[4]),
      .nvm_done_i(src_ev[5]), .serial_if_event_i(ev[2:0]),
      .uart0_event_i(ev[8:3]), .uart1_event_i(ev[14:9]),
      .irq_ack_i(irq_ack), .call_i(call), .ret_i(ret),
      .return_from_isr_i(return_from_isr), .pc_i(pc), .irq_req_o(irq_req),
      .irq_vector_o(vec), .return_pc_o(ret_pc),
      .stack_full_o(stack_full), .wake_o(wake));
   core_model core_model_inst (
      .clk_i(clk_i), .rst_i(rst_i), .take_delay_i(delay), .cmd_i(cmd),
      .irq_req_i(irq_req), .irq_ack_o(irq_ack), .call_o(call),
      .ret_o(ret), .return_from_isr_o(return_from_isr), .pc_o(pc));
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      sub_tick <= (cycles % 3 == 2);
      if (irq_ack === 1'b1 && irq_req === 1'b1) begin
         takes <= takes + 1;
         taken_vec <= vec;
         taken_pc <= pc;
      end
      if (wake === 1'b1) wakes <= wakes + 1;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rsp = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rsp, e);
   endtask
   task automatic core(input logic [1:0] c);
      cmd <= c;
      @(posedge clk_i);
      cmd <= 2'h0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic wt();
      t0 = takes;
      while (takes == t0) @(posedge clk_i);
   endtask
   task automatic pe(input logic [14:0] e, input logic [5:0] s);
      ev <= e;
      src_ev <= s;
      @(posedge clk_i);
      ev <= 15'h0;
      src_ev <= 6'h00;
   endtask
   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      n_errors++;
      complete_run();
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({ack, irq_req, stack_full, wake}, 32'h0);
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, {24'h0, rows[i].d});
         if (!rows[i].w) chk(rsp, {24'h0, rows[i].e});
      end
      bus(1'b1, OFS_GLOBAL, 32'h1);
      for (int i = 0; i < 15; i++) begin
         delay <= (i % 2) ? 4'h5 : 4'h0;
         w0 = wakes;
         pe(15'h1 << i, 6'h00);
         wt();
         chk(taken_vec, i < 3 ? 0 : (i < 9 ? 1 : 2));
         chk(wakes - w0, 1);
         rdc(OFS_REQ_FLAG, 32'h0);
         rdc(OFS_GLOBAL, 32'h0);
         rdc(OFS_STACK, 32'h1);
         core(2'h3);
         chk(ret_pc, taken_pc);
         rdc(OFS_GLOBAL, 32'h1);
      end
      delay <= 4'h2;
      bus(1'b1, OFS_GLOBAL, 32'h0);
      pe(15'h0201, 6'h00);
      bus(1'b1, OFS_GLOBAL, 32'h1);
      wt();
      chk(taken_vec, REQ_SIF);
      core(2'h3);
      wt();
      chk(taken_vec, REQ_UART1);
      core(2'h3);
      repeat (8) core(2'h1);
      // full flag is registered one edge after the level reaches eight
      rdc(OFS_STACK, 32'h18);
      chk(stack_full, 1'b1);
      pe(15'h0001, 6'h00);
      repeat (10) @(posedge clk_i);
      chk(irq_req, 1'b0);
      rdc(OFS_REQ_FLAG, 32'h1);
      // one pop makes room; more pops would let the core take mid-way
      core(2'h2);
      wt();
      chk(taken_vec, REQ_SIF);
      repeat (8) core(2'h2);
      rdc(OFS_GLOBAL, 32'h0);
      bus(1'b1, OFS_GLOBAL, 32'h1);
      bus(1'b1, OFS_REQ_EN, 32'h1F);
      bus(1'b1, OFS_SRC_EN, 32'h01);
      pe(15'h0, 6'h01);
      repeat (8) @(posedge clk_i);
      chk(irq_req, 1'b0);
      bus(1'b1, OFS_REQ_EN, 32'hFF);
      wt();
      chk(taken_vec, REQ_GRP0);
      core(2'h3);
      bus(1'b1, OFS_SRC_FLAG, 32'h0);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, OFS_SRC_EN, 32'h1 << i);
         pe(15'h0, 6'h01 << i);
         wt();
         chk(taken_vec, REQ_GRP0 + i / 2);
         rdc(OFS_SRC_FLAG, (32'h2 << i) - 1);
         rdc(OFS_REQ_FLAG, 32'h0);
         core(2'h3);
      end
      bus(1'b1, OFS_SRC_EN, 32'h0);
      w0 = wakes;
      pe(15'h0, 6'h3F);
      repeat (4) @(posedge clk_i);
      chk(wakes - w0, 0);
      rdc(OFS_SRC_FLAG, 32'h3F);
      bus(1'b1, OFS_SRC_FLAG, 32'h0);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, OFS_CLK_SRC, tb_src[i] << (i > 3 ? 2 : 0));
         bus(1'b1, i > 3 ? OFS_TB1_CTRL : OFS_TB0_CTRL, 32'h80 | tb_sel[i]);
         w0 = cycles;
         wt();
         chk(cycles - w0 >= tb_exp[i] - 4 && cycles - w0 <= tb_exp[i] + 12,
             1);
         chk(taken_vec, REQ_TB0 + (i > 3));
         bus(1'b1, i > 3 ? OFS_TB1_CTRL : OFS_TB0_CTRL, 32'h0);
         core(2'h3);
      end
      // reset in mid-run must bring the outputs and the OFS_REQ_EN and OFS_GLOBAL registers back to zero
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({ack, irq_req, stack_full, wake}, 32'h0);
      rdc(OFS_REQ_EN, 32'h0);
      rdc(OFS_GLOBAL, 32'h0);
      complete_run();
   end
endmodule
bind mcu_irq_ctrl mcu_irq_properties props_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .dat_o(dat_o), .ack_o(ack_o), .irq_ack_i(irq_ack_i), .call_i(call_i),
   .ret_i(ret_i), .return_from_isr_i(return_from_isr_i), .pc_i(pc_i),
   .irq_req_o(irq_req_o), .return_pc_o(return_pc_o),
   .stack_full_o(stack_full_o), .wake_o(wake_o));
